// ### design/nipc_pkg.sv
// nipc_pkg: constants and types of the nested interrupt controller
// Contract
// - equal priority: lower vector number wins
// - concurrent never preempts; nested preempts on higher
// - level held in flag bits 5 and 3
// - level codes 10,01,00,11; 11 masks all
// - trap still accepted at level 3
// - entry loads level from vector priority pair
// - four priority regs, pair per vector, reset ff
// - priority reg 3 upper nibble reads one
// - written pair 10 ignored, keeps old value
// - reset and trap set level to 11
// - raised priority of pending running vector re-enters
// - enable/wait/halt load 10; mask/trap load 11
// - return and restore ops reload popped flags
// - branch tests: level is 11, or not
// - ops change level inside routines too
// - reset fffe, trap fffc, no priority
// - fourteen vectors from fffa downward, step two
// - only listed sources end halt modes
// - lines: fall, rise, both, fall+low; 0,2 inverted
// - four lines, two fields, two invert bits
// - sense register writable only at level 3
// - changed sense value clears latched line requests
// - no stack overflow detection
// - pick highest priority above level, else stays latched
// - core stacks, then jumps to given vector
// - sense layout 7:6, 5, 4:3, 2; reset 00
// - field 00 fall+low,01 rise,10 fall,11 both
package nipc_pkg;
    localparam int NVEC = 14;
    localparam int NEXT = 4;
    localparam int EXT_VEC0 = 2;
    localparam int VEC_WAKE_TIMER = 0;
    localparam int VEC_TIME_BASE = 1;
    localparam int VEC_SPI = 8;
    localparam int LEVEL_BIT_HIGH_POS = 5;
    localparam int LEVEL_BIT_LOW_POS = 3;
    localparam logic [7:0] FLAGS_RST = 8'hea;
    localparam logic [1:0] LVL0 = 2'h2;
    localparam logic [1:0] LVL1 = 2'h1;
    localparam logic [1:0] LVL2 = 2'h0;
    localparam logic [1:0] LVL3 = 2'h3;
    localparam logic [7:0] PRIO_RST = 8'hff;
    localparam logic [7:0] PRIO3_RO_MASK = 8'hf0;
    localparam logic [7:0] ADDR_PRIO0 = 8'h24;
    localparam logic [7:0] ADDR_PRIO1 = 8'h25;
    localparam logic [7:0] ADDR_PRIO2 = 8'h26;
    localparam logic [7:0] ADDR_PRIO3 = 8'h27;
    localparam logic [7:0] ADDR_SENSE = 8'h28;
    localparam logic [7:0] SENSE_RST = 8'h00;
    localparam logic [7:0] SENSE_WR_MASK = 8'hfc;
    localparam int SENSE_F23_POS = 6;
    localparam int INV_B_POS = 5;
    localparam int SENSE_F01_POS = 3;
    localparam int INV_A_POS = 2;
    localparam logic [1:0] SENSE_FALL_LOW = 2'h0;
    localparam logic [1:0] SENSE_RISE = 2'h1;
    localparam logic [1:0] SENSE_FALL = 2'h2;
    localparam logic [1:0] SENSE_BOTH = 2'h3;
    localparam logic [15:0] VEC_RESET = 16'hfffe;
    localparam logic [15:0] VEC_TRAP = 16'hfffc;
    localparam logic [15:0] VEC_BASE = 16'hfffa;
    typedef enum logic [1:0] {HALT_NONE, HALT_PLAIN, HALT_ACTIVE, HALT_TIMED} nipc_halt_t;
    typedef enum logic {OFFER_IDLE, OFFER_HOLD} nipc_offer_t;
endpackage

// ### design/nipc_ext_if.sv
// nipc_ext_if: configuration and request of one external line
`timescale 1ns/100ps
interface nipc_ext_if;
    logic pin;
    logic [1:0] sense;
    logic invert;
    logic clear;
    logic flush;
    logic req;
    modport ctrl (output pin, output sense, output invert, output clear, output flush,
        input req);
    modport line (input pin, input sense, input invert, input clear, input flush,
        output req);
endinterface

// ### design/nipc_ext_line.sv
// nipc_ext_line: sensitivity detector and request latch of one external line
`timescale 1ns/100ps
module nipc_ext_line
    import nipc_pkg::*;
#(
    parameter bit HAS_INV = 1'b0
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // configuration and request
    nipc_ext_if.line lnk
);
    logic sync1_ff;
    logic sync2_ff;
    logic prev_ff;
    logic latch_ff;
    logic nxt_latch;

    // only lines with a polarity bit honour it
    wire inv = HAS_INV && lnk.invert;
    wire rise = sync2_ff && !prev_ff;
    wire fall = !sync2_ff && prev_ff;
    wire edge_hit = (lnk.sense == SENSE_BOTH) ? (rise | fall) :
        (lnk.sense == SENSE_RISE) ? (inv ? fall : rise) : (inv ? rise : fall);
    wire level_hit = (lnk.sense == SENSE_FALL_LOW) && (inv ? sync2_ff : !sync2_ff);

    // a new edge beats a clear in the same cycle
    assign nxt_latch = edge_hit | (latch_ff & !lnk.clear & !lnk.flush);
    assign lnk.req = latch_ff | level_hit;

    // idle high so reset does not fake a falling edge
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            sync1_ff <= 1'h1;
            sync2_ff <= 1'h1;
            prev_ff <= 1'h1;
            latch_ff <= 1'h0;
        end else begin
            sync1_ff <= lnk.pin;
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
            latch_ff <= nxt_latch;
        end
    end

    a_edge_latch: assert property (@(posedge clk_in) disable iff (srst_in)
        edge_hit |=> lnk.req)
        else $error("edge not latched");
endmodule

// ### design/nipc_top.sv
// nipc_top: nested interrupt controller with level bits, priorities and line sense
`timescale 1ns/100ps
module nipc_top
    import nipc_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // core instruction side effects
    input wire logic nested_mode_in,
    input wire logic op_enable_irq_in,
    input wire logic op_mask_irq_in,
    input wire logic op_wait_irq_in,
    input wire logic op_halt_in,
    input wire logic op_irq_return_in,
    input wire logic op_restore_flags_in,
    input wire logic [7:0] popped_flags_in,
    input wire logic trap_in,
    // service handshake with the core
    input wire logic irq_ack_in,
    output logic irq_req_out,
    output logic [15:0] irq_vector_out,
    output logic irq_is_trap_out,
    // flags and branch conditions
    output logic [7:0] cpu_flags_out,
    output logic [1:0] level_out,
    output logic branch_if_masked_out,
    output logic branch_if_unmasked_out,
    // sources and low power
    input wire logic [NVEC-1:0] periph_req_in,
    input wire logic [NEXT-1:0] ext_line_in,
    input wire nipc_halt_t halt_mode_in,
    input wire logic spi_slave_in,
    output logic wake_out
);
    logic [7:0] flags_ff;
    logic [7:0] nxt_flags;
    logic [7:0] prio_ff [4];
    logic [7:0] sense_ff;
    logic trap_pend_ff;
    nipc_offer_t offer_ff;
    logic offer_trap_ff;
    logic [3:0] offer_id_ff;
    logic [15:0] vector_ff;
    logic [7:0] rdata_ff;
    logic [7:0] rd_mux;
    logic win_found;
    logic [3:0] win_id;
    logic [1:0] win_rank;
    logic [NVEC-1:0] pend;
    logic [NVEC-1:0] elig;
    logic [NEXT-1:0] ext_req;

    function automatic logic [1:0] lvl_rank(input logic [1:0] code);
        case (code)
            LVL0: return 2'h0;
            LVL1: return 2'h1;
            LVL2: return 2'h2;
            default: return 2'h3;
        endcase
    endfunction

    function automatic logic [7:0] set_level(input logic [7:0] f, input logic [1:0] code);
        logic [7:0] r;
        r = f;
        r[LEVEL_BIT_HIGH_POS] = code[1];
        r[LEVEL_BIT_LOW_POS] = code[0];
        return r;
    endfunction

    function automatic logic [7:0] prio_merge(input logic [7:0] old, input logic [7:0] wr);
        logic [7:0] r;
        r = wr;
        for (int j = 0; j < 4; j++) begin
            if (wr[2*j +: 2] == LVL0) begin
                r[2*j +: 2] = old[2*j +: 2];
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] vec_addr(input logic [3:0] id);
        return VEC_BASE - {11'h0, id, 1'h0};
    endfunction

    // level and branch conditions
    wire [1:0] level = {flags_ff[LEVEL_BIT_HIGH_POS], flags_ff[LEVEL_BIT_LOW_POS]};
    wire [31:0] prio_flat = {prio_ff[3], prio_ff[2], prio_ff[1], prio_ff[0]};
    wire masked = (level == LVL3);
    assign level_out = level;
    assign cpu_flags_out = flags_ff;
    assign branch_if_masked_out = masked;
    assign branch_if_unmasked_out = !masked;

    // register port decode
    wire sel_p0 = (reg_addr_in == ADDR_PRIO0);
    wire sel_p1 = (reg_addr_in == ADDR_PRIO1);
    wire sel_p2 = (reg_addr_in == ADDR_PRIO2);
    wire sel_p3 = (reg_addr_in == ADDR_PRIO3);
    wire sel_sense = (reg_addr_in == ADDR_SENSE);
    wire [3:0] prio_wr = {4{reg_wr_in}} & {sel_p3, sel_p2, sel_p1, sel_p0};
    wire [7:0] sense_new = reg_wdata_in & SENSE_WR_MASK;
    // software must mask first; other writes are dropped silently
    wire sense_wr_ok = reg_wr_in && sel_sense && masked;
    wire sense_flush = sense_wr_ok && (sense_new != sense_ff);

    always_comb begin
        if (sel_p0) begin
            rd_mux = prio_ff[0];
        end else if (sel_p1) begin
            rd_mux = prio_ff[1];
        end else if (sel_p2) begin
            rd_mux = prio_ff[2];
        end else if (sel_p3) begin
            rd_mux = prio_ff[3] | PRIO3_RO_MASK;
        end else if (sel_sense) begin
            rd_mux = sense_ff;
        end else begin
            rd_mux = 8'h00;
        end
    end
    assign reg_rdata_out = rdata_ff;

    // offer and acceptance
    wire still_valid = offer_trap_ff ? trap_pend_ff :
        (!trap_pend_ff && win_found && (win_id == offer_id_ff));
    assign irq_req_out = (offer_ff == OFFER_HOLD) && still_valid;
    wire take = irq_req_out && irq_ack_in;
    assign irq_vector_out = vector_ff;
    assign irq_is_trap_out = offer_trap_ff;
    wire [1:0] entry_level = offer_trap_ff ? LVL3 : prio_flat[{offer_id_ff, 1'h0} +: 2];

    // external lines
    nipc_ext_if ext_if [NEXT] ();
    for (genvar k = 0; k < NEXT; k++) begin : g_line
        localparam int FPOS = (k < 2) ? SENSE_F01_POS : SENSE_F23_POS;
        localparam int IPOS = (k < 2) ? INV_A_POS : INV_B_POS;
        assign ext_if[k].pin = ext_line_in[k];
        assign ext_if[k].sense = sense_ff[FPOS +: 2];
        assign ext_if[k].invert = sense_ff[IPOS];
        assign ext_if[k].clear = take && !offer_trap_ff && (offer_id_ff == 4'(EXT_VEC0 + k));
        assign ext_if[k].flush = sense_flush;
        assign ext_req[k] = ext_if[k].req;
        nipc_ext_line #(
            .HAS_INV(k % 2 == 0)
        ) u_line (
            .clk_in(clk_in),
            .srst_in(srst_in),
            .lnk(ext_if[k])
        );
    end

    // pending and eligibility per vector
    for (genvar i = 0; i < NVEC; i++) begin : g_vec
        if (i >= EXT_VEC0 && i < EXT_VEC0 + NEXT) begin : g_ext
            assign pend[i] = ext_req[i - EXT_VEC0];
        end else begin : g_per
            assign pend[i] = periph_req_in[i];
        end
        // a raised priority on a still pending vector preempts its own routine
        assign elig[i] = pend[i] && (lvl_rank(prio_flat[2*i +: 2]) > lvl_rank(level))
            && (nested_mode_in || level == LVL0);
    end

    // highest rank wins; scanning downward lets the lower number win ties
    always_comb begin
        win_found = 1'h0;
        win_id = 4'h0;
        win_rank = 2'h0;
        for (int i = NVEC - 1; i >= 0; i--) begin
            if (elig[i] && (!win_found || lvl_rank(prio_flat[2*i +: 2]) >= win_rank)) begin
                win_found = 1'h1;
                win_id = 4'(i);
                win_rank = lvl_rank(prio_flat[2*i +: 2]);
            end
        end
    end

    // level bits: popped value first, then instructions, then entry
    always_comb begin
        nxt_flags = flags_ff;
        if (op_irq_return_in || op_restore_flags_in) begin
            nxt_flags = popped_flags_in;
        end else if (op_mask_irq_in) begin
            nxt_flags = set_level(flags_ff, LVL3);
        end else if (op_enable_irq_in || op_wait_irq_in || op_halt_in) begin
            nxt_flags = set_level(flags_ff, LVL0);
        end else if (take) begin
            nxt_flags = set_level(flags_ff, entry_level);
        end
    end

    // halt exit: only the capable sources, each in its own modes
    wire wake_src = (|pend[EXT_VEC0 +: NEXT]) || (pend[VEC_SPI] && spi_slave_in)
        || (pend[VEC_TIME_BASE] && halt_mode_in == HALT_ACTIVE)
        || (pend[VEC_WAKE_TIMER] && halt_mode_in == HALT_TIMED);
    assign wake_out = (halt_mode_in != HALT_NONE) && wake_src;

    // stack depth is the core's business; nesting is never limited here
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            flags_ff <= FLAGS_RST;
            trap_pend_ff <= 1'h0;
            rdata_ff <= 8'h00;
            sense_ff <= SENSE_RST;
        end else begin
            flags_ff <= nxt_flags;
            // trap pends even at level 3; a new trap wins over its own clear
            trap_pend_ff <= trap_in | (trap_pend_ff & !(take && offer_trap_ff));
            rdata_ff <= reg_rd_in ? rd_mux : 8'h00;
            if (sense_wr_ok) begin
                sense_ff <= sense_new;
            end
        end
    end

    for (genvar p = 0; p < 4; p++) begin : g_prio
        always_ff @(posedge clk_in) begin
            if (srst_in) begin
                prio_ff[p] <= PRIO_RST;
            end else if (prio_wr[p]) begin
                prio_ff[p] <= (p == 3) ? (prio_merge(prio_ff[p], reg_wdata_in) | PRIO3_RO_MASK)
                    : prio_merge(prio_ff[p], reg_wdata_in);
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            offer_ff <= OFFER_IDLE;
            offer_trap_ff <= 1'h0;
            offer_id_ff <= 4'h0;
            vector_ff <= VEC_RESET;
        end else begin
            case (offer_ff)
                OFFER_IDLE: begin
                    if (trap_pend_ff || win_found) begin
                        offer_ff <= OFFER_HOLD;
                        offer_trap_ff <= trap_pend_ff;
                        offer_id_ff <= win_id;
                        vector_ff <= trap_pend_ff ? VEC_TRAP : vec_addr(win_id);
                    end
                end
                default: begin
                    if (take || !still_valid) begin
                        offer_ff <= OFFER_IDLE;
                    end
                end
            endcase
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    a_prio_pair_keep: assert property (
        prio_wr[0] && reg_wdata_in[1:0] == LVL0 |=> prio_ff[0][1:0] == $past(prio_ff[0][1:0]))
        else $error("level 0 pair was stored");
    a_prio3_read_ones: assert property (
        reg_rd_in && sel_p3 |=> reg_rdata_out[7:4] == 4'hf)
        else $error("upper nibble not one");
    a_mask_op_level: assert property (
        op_mask_irq_in && !op_irq_return_in && !op_restore_flags_in |=> level == LVL3)
        else $error("mask op did not set level 3");
    a_entry_level: assert property (
        take && !offer_trap_ff && !op_irq_return_in && !op_restore_flags_in && !op_mask_irq_in
        && !op_enable_irq_in && !op_wait_irq_in && !op_halt_in
        |=> level == $past(prio_flat[{offer_id_ff, 1'h0} +: 2]))
        else $error("entry level wrong");
    a_req_above_level: assert property (
        irq_req_out && !offer_trap_ff |-> lvl_rank(entry_level) > lvl_rank(level))
        else $error("offer not above level");
    a_concurrent_hold: assert property (
        irq_req_out && !offer_trap_ff && !nested_mode_in |-> level == LVL0)
        else $error("concurrent preemption");
    a_trap_at_level3: assert property (
        trap_in && masked |-> ##[1:4] (irq_req_out && irq_is_trap_out))
        else $error("trap not offered");
    a_sense_locked: assert property (
        reg_wr_in && sel_sense && !masked |=> $stable(sense_ff))
        else $error("sense written while unmasked");
    a_vector_addr: assert property (
        irq_req_out && !offer_trap_ff |-> irq_vector_out == vec_addr(offer_id_ff))
        else $error("vector address wrong");

    // non-maskable path and instruction effects
    a_trap_vector: assert property (
        irq_req_out && offer_trap_ff |-> irq_vector_out == VEC_TRAP)
        else $error("trap vector wrong");
    a_trap_pending: assert property (
        trap_in |=> trap_pend_ff)
        else $error("trap not latched");
    a_trap_entry_level: assert property (
        take && offer_trap_ff && !op_irq_return_in && !op_restore_flags_in
        && !op_enable_irq_in && !op_wait_irq_in && !op_halt_in |=> level == LVL3)
        else $error("trap entry level not 3");
    a_restore_flags: assert property (
        op_irq_return_in || op_restore_flags_in |=> flags_ff == $past(popped_flags_in))
        else $error("flags not restored");
    a_enable_op_level: assert property (
        (op_enable_irq_in || op_wait_irq_in || op_halt_in) && !op_irq_return_in
        && !op_restore_flags_in && !op_mask_irq_in |=> level == LVL0)
        else $error("enable op did not set level 0");
    a_level3_blocks: assert property (
        masked |-> !irq_req_out || offer_trap_ff)
        else $error("maskable offered at level 3");
    a_take_drops_req: assert property (
        take |=> !irq_req_out)
        else $error("offer stayed after take");

    // register port, sense register and wake output
    a_sense_write: assert property (
        reg_wr_in && sel_sense && masked |=> sense_ff == $past(sense_new))
        else $error("sense write lost");
    a_sense_low_zero: assert property (
        sense_ff[1:0] == 2'h0)
        else $error("sense reserved bits set");
    a_prio3_upper: assert property (
        prio_ff[3][7:4] == 4'hf)
        else $error("upper nibble of priority reg 3 lost");
    a_prio_read: assert property (
        reg_rd_in && sel_p0 |=> reg_rdata_out == $past(prio_ff[0]))
        else $error("priority read data wrong");
    a_rdata_idle: assert property (
        !reg_rd_in |=> reg_rdata_out == 8'h00)
        else $error("read data not idle");
    a_wake_idle: assert property (
        halt_mode_in == HALT_NONE |-> !wake_out)
        else $error("wake outside halt");
endmodule

// ### bench/nipc_core_model.sv
// nipc_core_model: core side that accepts service offers after a set stall
`timescale 1ns/100ps
module nipc_core_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // service handshake
    input wire logic irq_req_in,
    input wire logic [3:0] stall_in,
    output logic irq_ack_out
);
    logic [3:0] cnt_ff;
    // stall stands for finishing the instruction and stacking
    always @(posedge clk_in) begin
        if (srst_in || !irq_req_in || irq_ack_out) begin
            cnt_ff <= 4'h0;
            irq_ack_out <= 1'b0;
        end else if (cnt_ff == stall_in) begin
            irq_ack_out <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 4'h1;
        end
    end
endmodule

// ### bench/nipc_top_test.sv
// nipc_top_test: scenario testbench of the nested interrupt controller
`timescale 1ns/100ps
module nipc_top_test;
    import nipc_pkg::*;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic [7:0] addr = 8'h00, wdata = 8'h00, popped = 8'h00, rdata, flags;
    logic wr = 1'b0, rd = 1'b0, nested = 1'b0, trap = 1'b0, spi = 1'b0;
    logic [5:0] ops = 6'h00;
    logic [13:0] periph = 14'h0000;
    logic [3:0] ext = 4'hf, stall = 4'h0;
    nipc_halt_t halt = HALT_NONE;
    logic ack, req, is_trap, br_m, br_u, wake;
    logic [15:0] vec;
    logic [1:0] level;
    int errors = 0;
    int num_checks = 0;

    always #50 clk_in = ~clk_in;

    nipc_top dut (.clk_in(clk_in), .srst_in(srst_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .nested_mode_in(nested), .op_enable_irq_in(ops[0]), .op_mask_irq_in(ops[1]),
        .op_wait_irq_in(ops[2]), .op_halt_in(ops[3]), .op_irq_return_in(ops[4]),
        .op_restore_flags_in(ops[5]), .popped_flags_in(popped), .trap_in(trap),
        .irq_ack_in(ack), .irq_req_out(req), .irq_vector_out(vec),
        .irq_is_trap_out(is_trap), .cpu_flags_out(flags), .level_out(level),
        .branch_if_masked_out(br_m), .branch_if_unmasked_out(br_u),
        .periph_req_in(periph), .ext_line_in(ext), .halt_mode_in(halt),
        .spi_slave_in(spi), .wake_out(wake));

    nipc_core_model core (.clk_in(clk_in), .srst_in(srst_in), .irq_req_in(req),
        .stall_in(stall), .irq_ack_out(ack));

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1;
        chk("read data", 16'(exp), 16'(rdata));
    endtask

    task automatic op(input int k, input logic [7:0] pv, input logic [1:0] lv);
        @(posedge clk_in);
        ops <= 6'(1 << k);
        popped <= pv;
        @(posedge clk_in);
        ops <= 6'h00;
        #1;
        chk("level", 16'(lv), 16'(level));
    endtask

    // waits for an offer, then for the core to take it
    task automatic offer(input logic [15:0] v, input logic t, input logic [1:0] lv);
        int n;
        n = 0;
        #1;
        while (req !== 1'b1 && n < 40) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        chk("offer", 16'h1, 16'(req));
        if (req !== 1'b1) results();
        chk("vector", v, vec);
        chk("trap flag", 16'(t), 16'(is_trap));
        while (req !== 1'b0 && n < 80) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        chk("offer end", 16'h0, 16'(req));
        chk("entry level", 16'(lv), 16'(level));
        if (req !== 1'b0) results();
    endtask

    task automatic quiet;
        repeat (8) @(posedge clk_in);
        #1;
        chk("no offer", 16'h0, 16'(req));
    endtask

    task automatic t_reset;
        rreg(8'h24, 8'hff);
        rreg(8'h27, 8'hff);
        rreg(8'h28, 8'h00);
        rreg(8'h30, 8'h00);
        chk("flags", 16'h00ea, 16'(flags));
        chk("masked", 16'h1, 16'(br_m));
        chk("unmasked", 16'h0, 16'(br_u));
        $display("reset test done");
    endtask

    task automatic t_prio;
        wreg(8'h24, 8'hcf);
        wreg(8'h24, 8'h64);
        rreg(8'h24, 8'h44);
        wreg(8'h27, 8'h00);
        rreg(8'h27, 8'hf0);
        wreg(8'h26, 8'hd7);
        rreg(8'h26, 8'hd7);
        $display("priority test done");
    endtask

    task automatic t_ops;
        logic [1:0] exp_lv [4] = '{2'h2, 2'h3, 2'h2, 2'h2};
        for (int k = 0; k < 4; k++) begin
            op(1, 8'h00, 2'h3);
            op(k, 8'h00, exp_lv[k]);
        end
        chk("unmasked", 16'h1, 16'(br_u));
        op(5, 8'h00, 2'h0);
        chk("flags", 16'h0000, 16'(flags));
        op(4, 8'h28, 2'h3);
        chk("flags", 16'h0028, 16'(flags));
        $display("instruction test done");
    endtask

    task automatic t_service;
        op(0, 8'h00, 2'h2);
        @(posedge clk_in);
        periph <= 14'h0600;
        offer(16'hffe8, 1'b0, 2'h1);
        quiet();
        @(posedge clk_in);
        periph <= 14'h1600;
        quiet();
        @(posedge clk_in);
        nested <= 1'b1;
        offer(16'hffe2, 1'b0, 2'h0);
        // raise the running, still pending vector above the current level
        wreg(8'h27, 8'h03);
        offer(16'hffe2, 1'b0, 2'h3);
        @(posedge clk_in);
        periph <= 14'h0000;
        nested <= 1'b0;
        op(4, 8'h22, 2'h2);
        $display("service test done");
    endtask

    task automatic t_trap;
        op(1, 8'h00, 2'h3);
        stall <= 4'h3;
        @(posedge clk_in);
        trap <= 1'b1;
        @(posedge clk_in);
        trap <= 1'b0;
        offer(16'hfffc, 1'b1, 2'h3);
        stall <= 4'h0;
        $display("trap test done");
    endtask

    task automatic t_sense;
        wreg(8'h28, 8'h10);
        rreg(8'h28, 8'h10);
        op(0, 8'h00, 2'h2);
        wreg(8'h28, 8'h08);
        rreg(8'h28, 8'h10);
        @(posedge clk_in);
        ext <= 4'hd;
        offer(16'hfff4, 1'b0, 2'h1);
        op(4, 8'h22, 2'h2);
        quiet();
        @(posedge clk_in);
        ext <= 4'hf;
        op(1, 8'h00, 2'h3);
        @(posedge clk_in);
        ext <= 4'hd;
        repeat (6) @(posedge clk_in);
        wreg(8'h28, 8'h18);
        op(0, 8'h00, 2'h2);
        quiet();
        $display("sense test done");
    endtask

    task automatic t_invert;
        op(1, 8'h00, 2'h3);
        // lines 0/1 rising only, line 0 inverted to falling
        wreg(8'h28, 8'h0c);
        op(0, 8'h00, 2'h2);
        @(posedge clk_in);
        ext <= 4'hc;
        offer(16'hfff6, 1'b0, 2'h0);
        op(4, 8'h22, 2'h2);
        quiet();
        // low level on line 3 stays requested after entry
        @(posedge clk_in);
        ext <= 4'h4;
        offer(16'hfff0, 1'b0, 2'h3);
        op(4, 8'h22, 2'h2);
        offer(16'hfff0, 1'b0, 2'h3);
        @(posedge clk_in);
        ext <= 4'hf;
        repeat (4) @(posedge clk_in);
        wreg(8'h28, 8'h00);
        op(0, 8'h00, 2'h2);
        quiet();
        $display("invert test done");
    endtask

    task automatic wk(input nipc_halt_t m, input logic [13:0] p, input logic e);
        @(posedge clk_in);
        halt <= m;
        periph <= p;
        spi <= p[8];
        @(posedge clk_in);
        #1;
        chk("wake", 16'(e), 16'(wake));
    endtask

    task automatic t_wake;
        op(1, 8'h00, 2'h3);
        wk(HALT_PLAIN, 14'h0200, 1'b0);
        wk(HALT_PLAIN, 14'h0100, 1'b1);
        wk(HALT_ACTIVE, 14'h0002, 1'b1);
        wk(HALT_ACTIVE, 14'h0001, 1'b0);
        wk(HALT_TIMED, 14'h0001, 1'b1);
        wk(HALT_TIMED, 14'h0002, 1'b0);
        wk(HALT_NONE, 14'h0000, 1'b0);
        $display("wake test done");
    endtask

    initial begin
        repeat (4) @(posedge clk_in);
        srst_in <= 1'b0;
        t_reset();
        t_prio();
        t_ops();
        t_service();
        t_trap();
        t_sense();
        t_invert();
        t_wake();
        results();
    end
endmodule
